// file: design/plsc_ctrl.sv
// Purpose: Low-power and management-mode state control driven by pins.
// Assumes: All request pins are asynchronous and active low; snoop_req,
//          save_done, ack_done and resume_req come from logic on mclk.
// Notes:   The reset input is honoured in every state, including sleep.

`timescale 1ns/1ps

// Operation
// - Halted plus sleep request enters sleep.
// - Sleep gates every clock except the PLL.
// - Sleep ignores snoops and interrupt requests.
// - Sleep reacts only to sleep and reset.
// - Sleep release returns to halted, restarting clocks.
// - Halt request stops core, keeps bus, interrupts.
// - Halted still snoops and latches interrupts.
// - Halt release restarts, services, then executes.
// - Halt request is asynchronous, synchronised inside.
// - Accepted management interrupt saves state, enters mode.
// - Management mode acknowledges, then fetches handler.
module plsc_ctrl (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clock_halt_request_n,
  input wire logic sleep_request_n,
  input wire logic sys_mgmt_irq_n,
  input wire logic intr_req_n,
  input wire logic snoop_req,
  input wire logic save_done,
  input wire logic ack_done,
  input wire logic resume_req,
  output plsc_pkg::plsc_out_t pm_out,
  output logic snoop_ack,
  output logic intr_pending,
  output plsc_pkg::plsc_state_t pm_state
);
  import plsc_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------

  logic [PLSC_NUM_ASYNC-1:0] async_bus;   // Raw pins, bundled.
  logic [PLSC_NUM_ASYNC-1:0] sync_bus;    // Pins after two flops.
  logic halt_s;                           // Halt request, active high.
  logic sleep_s;                          // Sleep request, active high.
  logic smi_s;                            // Management irq, active high.
  logic intr_s;                           // Interrupt request, high.
  logic smi_s_d_r;                        // Last smi_s, for edge finding.
  logic smi_pend_r, smi_pend_nxt;         // Accepted-later management irq.
  logic intr_pend_r, intr_pend_nxt;       // Interrupt latched while halted.
  logic snoop_ack_r, snoop_ack_nxt;       // Snoop answered this cycle.
  plsc_state_t state_r, state_nxt;        // Operating state.
  plsc_out_t out_r, out_nxt;              // Registered output bundle.

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------

  // Pins are gathered so one synchroniser instance covers them all.
  always_comb begin
    async_bus = PLSC_ASYNC_IDLE;
    async_bus[PLSC_BIT_HALT] = clock_halt_request_n;
    async_bus[PLSC_BIT_SLEEP] = sleep_request_n;
    async_bus[PLSC_BIT_SMI] = sys_mgmt_irq_n;
    async_bus[PLSC_BIT_INTR] = intr_req_n;
  end

  // The halt request may change at any moment relative to mclk.
  plsc_sync #(
    .WIDTH(PLSC_NUM_ASYNC),
    .IDLE(PLSC_ASYNC_IDLE)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .async_in(async_bus),
    .sync_out(sync_bus)
  );

  // Only second-stage values are read from here on.
  assign halt_s = ~sync_bus[PLSC_BIT_HALT];
  assign sleep_s = ~sync_bus[PLSC_BIT_SLEEP];
  assign smi_s = ~sync_bus[PLSC_BIT_SMI];
  assign intr_s = ~sync_bus[PLSC_BIT_INTR];

  // ----------------------------------------------------------------------
  // Output decode
  // ----------------------------------------------------------------------

  // Maps a state to the clock enables and status it shows.
  function automatic plsc_out_t plsc_decode(input plsc_state_t st);
    plsc_out_t o;
    o = PLSC_OUT_RESET;
    case (st)
      PLSC_HALT: begin
        o.core_clk_en = 1'b0;
        o.exec_en = 1'b0;
      end
      PLSC_SLEEP: begin
        // Only the PLL keeps running, so wake-up needs no relock.
        o.core_clk_en = 1'b0;
        o.bus_clk_en = 1'b0;
        o.intr_clk_en = 1'b0;
        o.snoop_en = 1'b0;
        o.exec_en = 1'b0;
      end
      PLSC_SVC: begin
        o.exec_en = 1'b0;
        o.intr_service = 1'b1;
      end
      PLSC_SMM_SAVE: begin
        o.exec_en = 1'b0;
        o.state_save_req = 1'b1;
        o.sys_mgmt_mode = 1'b1;
      end
      PLSC_SMM_ACK: begin
        o.exec_en = 1'b0;
        o.smi_ack_req = 1'b1;
        o.sys_mgmt_mode = 1'b1;
      end
      PLSC_SMM_RUN: begin
        o.handler_fetch = 1'b1;
        o.sys_mgmt_mode = 1'b1;
      end
      default: begin
        o = PLSC_OUT_RESET;
      end
    endcase
    return o;
  endfunction : plsc_decode

  // ----------------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------------

  // Next state; management entry waits for the running state so that a
  // halted or sleeping core is never woken by it behind chipset's back.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PLSC_RUN: begin
        // A sleep request here is not acted on at all.
        if (halt_s) begin
          state_nxt = PLSC_HALT;
        end else if (smi_pend_r) begin
          state_nxt = PLSC_SMM_SAVE;
        end
      end
      PLSC_HALT: begin
        // Sleep wins only while the halt request is still held.
        if (halt_s && sleep_s) begin
          state_nxt = PLSC_SLEEP;
        end else if (!halt_s) begin
          state_nxt = intr_pend_r ? PLSC_SVC : PLSC_RUN;
        end
      end
      PLSC_SLEEP: begin
        // Only the sleep level is watched; halt release waits for it.
        if (!sleep_s) begin
          state_nxt = PLSC_HALT;
        end
      end
      PLSC_SVC: begin
        state_nxt = PLSC_RUN;
      end
      PLSC_SMM_SAVE: begin
        if (save_done) begin
          state_nxt = PLSC_SMM_ACK;
        end
      end
      PLSC_SMM_ACK: begin
        if (ack_done) begin
          state_nxt = PLSC_SMM_RUN;
        end
      end
      PLSC_SMM_RUN: begin
        if (resume_req) begin
          state_nxt = PLSC_RUN;
        end
      end
      default: begin
        state_nxt = PLSC_RUN;
      end
    endcase
    out_nxt = plsc_decode(state_nxt); // Registered as the output bundle.
  end

  // ----------------------------------------------------------------------
  // Pending events and snoop answer
  // ----------------------------------------------------------------------

  // Set wins over clear for both pending flags.
  always_comb begin
    smi_pend_nxt = smi_pend_r;
    intr_pend_nxt = intr_pend_r;
    if (state_r == PLSC_RUN && state_nxt == PLSC_SMM_SAVE) begin
      smi_pend_nxt = 1'b0;
    end
    if (state_r == PLSC_SVC) begin
      intr_pend_nxt = 1'b0;
    end
    // Sleep drops new management requests and interrupts.
    if (state_r != PLSC_SLEEP && smi_s && !smi_s_d_r) begin
      smi_pend_nxt = 1'b1;
    end
    if (state_r == PLSC_HALT && intr_s) begin
      intr_pend_nxt = 1'b1;
    end
    snoop_ack_nxt = snoop_req && state_r != PLSC_SLEEP;
  end

  // Registers only; reset loads constants.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= PLSC_RUN;
      out_r <= PLSC_OUT_RESET;
      smi_s_d_r <= 1'b0;
      smi_pend_r <= 1'b0;
      intr_pend_r <= 1'b0;
      snoop_ack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      out_r <= out_nxt;
      smi_s_d_r <= smi_s;
      smi_pend_r <= smi_pend_nxt;
      intr_pend_r <= intr_pend_nxt;
      snoop_ack_r <= snoop_ack_nxt;
    end
  end

  assign pm_out = out_r;
  assign snoop_ack = snoop_ack_r;
  assign intr_pending = intr_pend_r;
  assign pm_state = state_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_sleep_entry: assert property (
    state_r == PLSC_HALT && halt_s && sleep_s |=> state_r == PLSC_SLEEP)
    else $error("Halted with sleep request did not enter sleep.");
  a_sleep_clocks: assert property (
    state_r == PLSC_SLEEP |-> pm_out.pll_en && !pm_out.core_clk_en &&
      !pm_out.bus_clk_en && !pm_out.intr_clk_en)
    else $error("Sleep clocks wrong.");
  a_sleep_deaf: assert property (
    state_r == PLSC_SLEEP && $past(state_r) == PLSC_SLEEP |->
      !snoop_ack && $stable(intr_pend_r))
    else $error("Sleep answered a snoop or latched an interrupt.");
  a_sleep_only_pins: assert property (
    state_r == PLSC_SLEEP && sleep_s |=> state_r == PLSC_SLEEP)
    else $error("Sleep left without sleep release.");
  a_sleep_exit: assert property (
    state_r == PLSC_SLEEP && !sleep_s |=>
      state_r == PLSC_HALT && pm_out.bus_clk_en && pm_out.intr_clk_en)
    else $error("Sleep release did not return to halted.");
  a_halt_entry: assert property (
    state_r == PLSC_RUN && halt_s |=> state_r == PLSC_HALT &&
      !pm_out.core_clk_en && pm_out.bus_clk_en && pm_out.intr_clk_en)
    else $error("Halt entry wrong.");
  a_halt_latch: assert property (
    state_r == PLSC_HALT && intr_s |=> intr_pend_r)
    else $error("Interrupt not latched while halted.");
  a_halt_resume: assert property (
    state_r == PLSC_HALT && !halt_s && intr_pend_r |=>
      pm_out.intr_service && !pm_out.exec_en ##1
      state_r == PLSC_RUN && pm_out.exec_en)
    else $error("Resume did not service then execute.");
  a_halt_sync: assert property (
    $past(rst_b, 2) |-> halt_s == !$past(clock_halt_request_n, 2) &&
      sleep_s == !$past(sleep_request_n, 2))
    else $error("Synchroniser delay not two cycles.");
  a_smi_enter: assert property (
    state_r == PLSC_RUN && !halt_s && smi_pend_r |=>
      pm_out.state_save_req && pm_out.sys_mgmt_mode)
    else $error("Management irq not accepted.");
  a_smi_ack: assert property (
    state_r == PLSC_SMM_SAVE && save_done |=> pm_out.smi_ack_req)
    else $error("Save done did not start the acknowledge.");
  a_smi_fetch: assert property (
    $rose(pm_out.handler_fetch) |-> $past(pm_out.smi_ack_req && ack_done))
    else $error("Handler fetch began without a finished acknowledge.");
  a_sleep_ignored: assert property (
    state_r == PLSC_RUN && sleep_s && !halt_s && !smi_pend_r |=>
      state_r == PLSC_RUN)
    else $error("Sleep request acted on outside halted.");

  c_sleep_cycle: cover property (
    state_r == PLSC_HALT ##1 state_r == PLSC_SLEEP ##[1:50]
      state_r == PLSC_HALT);
  c_halt_service: cover property (state_r == PLSC_SVC);
  c_smm_entry: cover property (pm_out.handler_fetch);

endmodule : plsc_ctrl

// file: design/plsc_pkg.sv
// Purpose: Shared types and constants for the low-power state control.
// Assumes: One clock, mclk at 10 MHz, and an active-low async reset.
// Notes:   Output groups travel as one packed struct.

package plsc_pkg;

  // ----------------------------------------------------------------------
  // Synchroniser and input bit positions
  // ----------------------------------------------------------------------

  // Number of flip-flops every asynchronous input passes through.
  localparam int PLSC_SYNC_STAGES = 2;
  // Width of the bundle of asynchronous inputs.
  localparam int PLSC_NUM_ASYNC = 4;
  // Bit positions of each input inside the synchroniser bundle.
  localparam int PLSC_BIT_HALT = 0;
  localparam int PLSC_BIT_SLEEP = 1;
  localparam int PLSC_BIT_SMI = 2;
  localparam int PLSC_BIT_INTR = 3;
  // Idle level of the bundle; every input is active low.
  localparam logic [PLSC_NUM_ASYNC-1:0] PLSC_ASYNC_IDLE = 4'hf;

  // ----------------------------------------------------------------------
  // Operating states
  // ----------------------------------------------------------------------

  typedef enum logic [2:0] {
    PLSC_RUN,        // Normal execution, all clocks running.
    PLSC_HALT,       // Core clocks stopped, bus and interrupt unit live.
    PLSC_SLEEP,      // Only the PLL runs.
    PLSC_SVC,        // Servicing interrupts latched while halted.
    PLSC_SMM_SAVE,   // Saving processor state for management mode.
    PLSC_SMM_ACK,    // Issuing the management acknowledge transaction.
    PLSC_SMM_RUN     // Fetching from the management handler.
  } plsc_state_t;

  // ----------------------------------------------------------------------
  // Output bundle
  // ----------------------------------------------------------------------

  typedef struct packed {
    logic pll_en;          // Phase-locked loop running.
    logic core_clk_en;     // Clock to the core units.
    logic bus_clk_en;      // Clock to the bus unit.
    logic intr_clk_en;     // Clock to the local_intr_ctrl_unit.
    logic snoop_en;        // Bus snoops are honoured.
    logic exec_en;         // Instruction execution allowed.
    logic intr_service;    // Latched interrupts are being serviced.
    logic state_save_req;  // Save of processor state in progress.
    logic smi_ack_req;     // Acknowledge bus transaction requested.
    logic handler_fetch;   // Fetching from the management handler.
    logic sys_mgmt_mode;   // Processor is in management mode.
  } plsc_out_t;

  // Value of the output bundle during and right after reset.
  localparam plsc_out_t PLSC_OUT_RESET = '{
    pll_en: 1'b1, core_clk_en: 1'b1, bus_clk_en: 1'b1, intr_clk_en: 1'b1,
    snoop_en: 1'b1, exec_en: 1'b1, intr_service: 1'b0,
    state_save_req: 1'b0, smi_ack_req: 1'b0, handler_fetch: 1'b0,
    sys_mgmt_mode: 1'b0};

endpackage : plsc_pkg

// file: design/plsc_sync.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous inputs.
// Assumes: Inputs are independent levels; no bus coherency is promised.
// Notes:   Stage one feeds stage two only, never any other logic.

`timescale 1ns/1ps

module plsc_sync #(
  parameter int WIDTH = plsc_pkg::PLSC_NUM_ASYNC,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import plsc_pkg::*;

  // First stage, which may go metastable.
  logic [WIDTH-1:0] meta_r;

  // ----------------------------------------------------------------------
  // Two register stages
  // ----------------------------------------------------------------------

  // Reset loads the idle level so nothing looks asserted at release.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= IDLE;
      sync_out <= IDLE;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : plsc_sync

// file: verif/plsc_chipset_model.sv
// Purpose: Behavioural chipset model driving the power-management pins.
// Assumes: Intent inputs change on the falling edge of mclk.
// Notes:   Pins lag their intents by a skew so they look asynchronous.

`timescale 1ns/1ps

module plsc_chipset_model #(
  parameter int SKEW_NS = 23
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic halt_w,
  input wire logic sleep_w,
  input wire logic smi_w,
  input wire logic intr_w,
  input wire logic slow,
  input wire logic state_save_req,
  input wire logic smi_ack_req,
  output logic clock_halt_request_n,
  output logic sleep_request_n,
  output logic sys_mgmt_irq_n,
  output logic intr_req_n,
  output logic save_done,
  output logic ack_done
);
  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------

  // The skew keeps pin edges well away from any clock edge.
  assign #SKEW_NS clock_halt_request_n = !halt_w;
  assign #SKEW_NS sleep_request_n = !sleep_w;
  assign #SKEW_NS sys_mgmt_irq_n = !smi_w;
  assign #SKEW_NS intr_req_n = !intr_w;

  // ----------------------------------------------------------------------
  // Save and acknowledge handshake
  // ----------------------------------------------------------------------

  logic [3:0] cnt; // Cycles waited for the current request.

  // A slow partner answers five cycles late, a prompt one at once.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 4'h0;
      save_done <= 1'b0;
      ack_done <= 1'b0;
    end else begin
      save_done <= 1'b0;
      ack_done <= 1'b0;
      if ((state_save_req && !save_done) || (smi_ack_req && !ack_done)) begin
        if (cnt == (slow ? 4'h5 : 4'h0)) begin
          cnt <= 4'h0;
          save_done <= state_save_req;
          ack_done <= smi_ack_req;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end

endmodule : plsc_chipset_model

// file: verif/tb.sv
// Purpose: Self-checking bench for the low-power state control.
// Assumes: Stimulus changes on the falling edge of mclk.
// Notes:   Pin effects are awaited under bounded counts.

`timescale 1ns/1ps

module tb;
  import plsc_pkg::*;

  // ----------------------------------------------------------------------
  // Signals and table
  // ----------------------------------------------------------------------

  typedef struct packed {
    logic [4:0] want; // Halt, sleep, smi, intr, snoop requests.
    plsc_state_t st;
    logic [10:0] out;
    logic ack;
    logic pend;
  } plsc_row_t;

  logic mclk, rst_b, halt_w, sleep_w, smi_w, intr_w, slow, hit;
  logic snoop_req, resume_req, save_done, ack_done, snoop_ack;
  logic intr_pending, halt_n, sleep_n, smi_n, intr_n;
  plsc_out_t pm_out;
  plsc_state_t pm_state;
  int error_cnt = 0;
  int compares = 0;

  // Steady states reached from the pins, in order.
  plsc_row_t rows [6] = '{
    '{5'h01, PLSC_RUN, 11'h7e0, 1'b1, 1'b0},
    '{5'h08, PLSC_RUN, 11'h7e0, 1'b0, 1'b0},
    '{5'h11, PLSC_HALT, 11'h5c0, 1'b1, 1'b0},
    '{5'h19, PLSC_SLEEP, 11'h400, 1'b0, 1'b0},
    '{5'h1f, PLSC_SLEEP, 11'h400, 1'b0, 1'b0},
    '{5'h10, PLSC_HALT, 11'h5c0, 1'b0, 1'b0}};

  plsc_ctrl plsc_ctrl_inst (.mclk(mclk), .rst_b(rst_b),
    .clock_halt_request_n(halt_n), .sleep_request_n(sleep_n),
    .sys_mgmt_irq_n(smi_n), .intr_req_n(intr_n), .snoop_req(snoop_req),
    .save_done(save_done), .ack_done(ack_done), .resume_req(resume_req),
    .pm_out(pm_out), .snoop_ack(snoop_ack), .intr_pending(intr_pending),
    .pm_state(pm_state));

  plsc_chipset_model plsc_chipset_model_inst (.mclk(mclk), .rst_b(rst_b),
    .halt_w(halt_w), .sleep_w(sleep_w), .smi_w(smi_w), .intr_w(intr_w),
    .slow(slow), .state_save_req(pm_out.state_save_req),
    .smi_ack_req(pm_out.smi_ack_req), .clock_halt_request_n(halt_n),
    .sleep_request_n(sleep_n), .sys_mgmt_irq_n(smi_n), .intr_req_n(intr_n),
    .save_done(save_done), .ack_done(ack_done));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------

  task check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask : check

  // Polls each edge, since the synchroniser phase shifts answers by one.
  task wait_st(input plsc_state_t st, input int lim);
    hit = 1'b0;
    for (int k = 0; k < lim && !hit; k++) begin
      @(posedge mclk);
      #1;
      hit = (pm_state === st);
    end
  endtask : wait_st

  task test_done;
    $display("Errors: %0d Compares: %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------------------------------------

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // The tests need about a hundred cycles; this span means a hang.
  initial begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    test_done();
  end

  initial begin
    rst_b = 1'b0;
    {halt_w, sleep_w, smi_w, intr_w, snoop_req} = 5'h00;
    {slow, resume_req} = 2'b00;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    foreach (rows[i]) begin
      {halt_w, sleep_w, smi_w, intr_w, snoop_req} = rows[i].want;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      check({13'h0, pm_state}, {13'h0, rows[i].st});
      check({5'h0, pm_out}, {5'h0, rows[i].out});
      check({15'h0, snoop_ack}, {15'h0, rows[i].ack});
      check({15'h0, intr_pending}, {15'h0, rows[i].pend});
    end
    // An interrupt while halted is latched and served on release.
    intr_w = 1'b1;
    repeat (4) @(negedge mclk);
    check({15'h0, intr_pending}, 16'h1);
    intr_w = 1'b0;
    halt_w = 1'b0;
    wait_st(PLSC_SVC, 5);
    check({15'h0, hit & pm_out.intr_service}, 16'h1);
    @(posedge mclk);
    #1;
    check({13'h0, pm_state}, {13'h0, PLSC_RUN});
    check({15'h0, pm_out.exec_en}, 16'h1);
    // The management edge given during sleep must have been lost.
    repeat (6) @(posedge mclk);
    #1;
    check({13'h0, pm_state}, {13'h0, PLSC_RUN});
    // Management entry, first with a prompt then a slow partner.
    for (int s = 0; s < 2; s++) begin
      @(negedge mclk);
      slow = s[0];
      smi_w = 1'b1;
      wait_st(PLSC_SMM_SAVE, 6);
      check({15'h0, hit & pm_out.state_save_req}, 16'h1);
      wait_st(PLSC_SMM_ACK, 12);
      check({15'h0, hit & pm_out.smi_ack_req}, 16'h1);
      wait_st(PLSC_SMM_RUN, 12);
      check({15'h0, hit & pm_out.handler_fetch}, 16'h1);
      check({14'h0, pm_out.sys_mgmt_mode, pm_out.exec_en}, 16'h3);
      @(negedge mclk);
      smi_w = 1'b0;
      resume_req = 1'b1;
      @(negedge mclk);
      resume_req = 1'b0;
      wait_st(PLSC_RUN, 4);
      check({15'h0, hit}, 16'h1);
    end
    // Reset must still be obeyed in sleep.
    @(negedge mclk);
    halt_w = 1'b1;
    repeat (5) @(negedge mclk);
    sleep_w = 1'b1;
    repeat (5) @(negedge mclk);
    check({13'h0, pm_state}, {13'h0, PLSC_SLEEP});
    rst_b = 1'b0;
    #1;
    check({13'h0, pm_state}, {13'h0, PLSC_RUN});
    check({5'h0, pm_out}, {5'h0, PLSC_OUT_RESET});
    @(negedge mclk);
    {halt_w, sleep_w} = 2'b00;
    @(negedge mclk);
    rst_b = 1'b1;
    repeat (5) @(negedge mclk);
    check({13'h0, pm_state}, {13'h0, PLSC_RUN});
    test_done();
  end

endmodule : tb
